//--- tecap_assertions.sv
// Port-level checker of the timer event count and capture unit
`timescale 1ns/1ps
`default_nettype none
module tecap_checker
    import tecap_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NUM_CH-1:0] timer_input_pin,
    input wire logic              serial_receive_pin,
    input wire logic [NUM_CH-1:0] channel_interrupt,
    input wire logic [NUM_CH-1:0] timer_output_value
);
    // ********************************************************************
    // Bus handshake, read-back and output checks
    // ********************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup phase of any transfer and of a read, decoded once for several checks
    logic setup;
    logic rd_setup;
    assign setup    = psel && !penable;
    assign rd_setup = setup && !pwrite;

    a_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (setup && paddr >= 12'h024 && paddr <= 12'h03c
        |=> pslverr)
        else $error("unmapped access not refused");
    a_trigger_reads_zero: assert property (rd_setup && (paddr == ADDR_START ||
        paddr == ADDR_STOP) |=> prdata == 32'h0)
        else $error("trigger bits did not clear");
    a_counter_width: assert property (rd_setup && paddr >= 12'h040 && paddr <= 12'h07c
        |=> prdata[31:16] == 16'h0)
        else $error("channel read wider than 16 bits");
    a_irq_single: assert property ((channel_interrupt & $past(channel_interrupt)) == 4'h0)
        else $error("interrupt longer than one cycle");
    // Output may only move on an interrupt or a write; unit disable clears it a cycle late
    a_tout_cause: assert property ($changed(timer_output_value) |-> (|channel_interrupt) ||
        $past(|channel_interrupt) || $past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))
        else $error("timer output changed without cause");
endmodule : tecap_checker
`default_nettype wire

//--- tecap_bench.sv
// Self-checking bench of the timer event count and capture unit
`timescale 1ns/1ps
`default_nettype none
module tecap_bench
    import tecap_pkg::*;
;
    // ********************************************************************
    // Signals, notes and counters
    // ********************************************************************
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic r;} tecap_note_s;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, srx;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, v;
    logic [NUM_CH-1:0] tin, irq, tout;
    tecap_note_s       nq[$];
    tecap_note_s       nt;
    logic [3:0]        iq[$];
    int                mismatches, checked, seed;

    always #5 pclk = ~pclk;

    tecap_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin(tin), .serial_receive_pin(srx),
        .channel_interrupt(irq), .timer_output_value(tout));
    tecap_pulse_source src (.pclk(pclk), .timer_input_pin(tin), .serial_receive_pin(srx));

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        begin
            checked++;
            if (s !== e)
            begin
                mismatches++;
                $display("[FAIL] %s expected %h seen %h", n, e, s);
            end
        end
    endtask : check

    task automatic final_report;
        begin
            $display("checks %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask : final_report

    // One transfer; the idle cycle after it keeps drivers from double assignment
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] m, input logic er);
        begin
            nq.push_back({e, m, er});
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            psel <= 1'b0; penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    // Upper write bits are unused by every register, so they carry noise
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        begin
            r = $random(seed);
            apb(1'b1, a, {r[31:16], d[15:0]}, 32'h0, 32'h0, 1'b0);
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 32'hffffffff, 1'b0);
    endtask : rd

    // ********************************************************************
    // Watcher: each bus answer takes the oldest note, each interrupt the oldest expected value in iq
    // ********************************************************************
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            nt = nq.pop_front();
            check("prdata", prdata & nt.m, nt.e & nt.m);
            check("pslverr", 32'(pslverr), 32'(nt.r));
        end
        if (presetn && irq !== 4'h0)
            check("irq", 32'(irq), (iq.size() > 0) ? 32'(iq.pop_front()) : 32'h0);
    end

    // Overflow wait dominates the run, so the limit sits about half again above it
    initial
    begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        final_report;
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; seed = 32'h3ccf8286; mismatches = 0; checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(ADDR_PER, 32'h1);
        wr(ADDR_PS, 32'h0);
        rd(ADDR_EN, 32'h0);
        wr(12'h040, 32'h0046); wr(12'h044, 32'h2); wr(ADDR_TOE, 32'h0);
        wr(ADDR_START, 32'h1);
        rd(ADDR_EN, 32'h1); rd(ADDR_START, 32'h0); rd(12'h048, 32'h2);
        src.burst(0, 1, 4);
        rd(12'h048, 32'h1);
        wr(12'h044, 32'h0); rd(12'h048, 32'h1);
        iq.push_back(4'h1); src.burst(0, 2, 4);
        iq.push_back(4'h1); src.burst(0, 1, 4);
        wr(ADDR_STOP, 32'h1); rd(ADDR_EN, 32'h0); rd(ADDR_STOP, 32'h0);
        src.burst(0, 1, 4); rd(12'h048, 32'h0);
        // A one-cycle glitch must die in the filter, a wide pulse must pass
        wr(ADDR_NF, 32'h1); wr(ADDR_START, 32'h1); src.burst(0, 1, 1);
        iq.push_back(4'h1); src.burst(0, 1, 5);
        wr(ADDR_STOP, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(12'h064, v); rd(12'h064, {16'h0, v[15:0]});
        end
        // Both edges of one pulse count, reload 1 gives one interrupt
        wr(12'h060, 32'h0086); wr(12'h064, 32'h1); wr(ADDR_TO, 32'h4); wr(ADDR_START, 32'h4);
        iq.push_back(4'h4); src.burst(2, 1, 4);
        rd(ADDR_TO, 32'h4);
        // Channel 7 counts falling edges only
        wr(ADDR_ISC, 32'h2); wr(12'h070, 32'h0006); wr(12'h074, 32'h0); wr(ADDR_START, 32'h8);
        src.burst(3, 1, 4);
        iq.push_back(4'h8); src.burst(4, 1, 4);
        // Capture: transfers are three cycles apart, so the interval is known
        wr(12'h050, 32'h0144); wr(ADDR_START, 32'h2);
        iq.push_back(4'h2); iq.push_back(4'h2); wr(ADDR_START, 32'h2); wr(ADDR_START, 32'h2);
        rd(12'h054, 32'h2); rd(12'h05c, 32'h0);
        iq.push_back(4'h2); src.burst(1, 1, 4);
        // A stopped channel and a switched-off line get noise that must not count
        for (int i = 0; i < 66000; i++)
        begin
            @(posedge pclk);
            v = $random(seed);
            src.set_line(0, v[0]); src.set_line(3, v[1]);
        end
        @(posedge pclk);
        src.set_line(0, 1'b0); src.set_line(3, 1'b0);
        iq.push_back(4'h2); wr(ADDR_START, 32'h2); rd(12'h05c, 32'h1);
        iq.push_back(4'h2); wr(ADDR_START, 32'h2); rd(12'h05c, 32'h0);
        rd(12'h054, 32'h5);
        // Clock d runs every cycle and clock a every other, so picking clock d reads 2
        wr(ADDR_PS, 32'h1); wr(12'h040, 32'hc145); iq.push_back(4'h1); wr(ADDR_START, 32'h1);
        iq.push_back(4'h1); wr(ADDR_START, 32'h1); rd(12'h044, 32'h2);
        wr(ADDR_PER, 32'h0); wr(12'h040, 32'h0046); wr(ADDR_PER, 32'h1);
        rd(12'h040, 32'h0); rd(ADDR_EN, 32'h0); rd(12'h054, 32'h0);
        apb(1'b0, 12'h030, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h080, 32'h0, 32'h0, 32'h0, 1'b1);
        check("tout", 32'(tout), 32'h0);
        check("irq_left", 32'(iq.size()), 32'h0);
        final_report;
    end
endmodule : tecap_bench

bind tecap_top tecap_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
    .serial_receive_pin(serial_receive_pin), .channel_interrupt(channel_interrupt),
    .timer_output_value(timer_output_value));
`default_nettype wire

//--- tecap_channel.sv
// One event count / interval capture channel
`timescale 1ns/1ps
`default_nettype none
module tecap_channel
    import tecap_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clr,
    input  wire logic             tick,
    input  wire logic             filt_en,
    input  wire logic             pin,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic             toe,
    input  wire logic             mode_wr,
    input  wire logic             data_wr,
    input  wire logic             to_wr,
    input  wire logic [15:0]      wdata,
    output tecap_ch_s             st
);

    tecap_ch_s n;
    logic      filt_new;
    logic      edge_ok;
    logic      is_event;
    logic      is_capt;
    logic      cap;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb
    begin
        n        = st;
        n.intr   = 1'b0;
        is_event = (st.mode.op_mode == OPM_EVENT);
        is_capt  = (st.mode.op_mode == OPM_CAPTURE);
        // Samples only on the operation clock tick, hence one-tick jitter
        filt_new = st.filt;                                         // RQ16
        if (tick)
        begin
            n.samp = {st.samp[0], pin};
            if (!filt_en || (st.samp[0] == pin && st.samp[1] == pin)) // RQ3
                filt_new = pin;
        end
        n.filt = filt_new;
        // Edge detection on the filtered level
        unique case (st.mode.edge_select)
            CIS_FALL: edge_ok = st.filt & ~filt_new;
            CIS_RISE: edge_ok = ~st.filt & filt_new;
            default:  edge_ok = st.filt ^ filt_new;
        endcase
        if (mode_wr)
            n.mode = tecap_mode_s'(wdata);
        if (data_wr)
            n.data = wdata;                                         // RQ24
        if (to_wr)
            n.tout = wdata[0];
        cap = 1'b0;
        if (start && !st.en)
        begin
            n.en      = 1'b1;                                       // RQ5
            n.cnt     = is_event ? st.data : CNT_ZERO;              // RQ6 RQ10
            n.wrapped = 1'b0;
            n.intr    = st.mode.start_interrupt_select;
        end
        else if (st.en && is_event)
        begin
            if (edge_ok)
            begin
                if (st.cnt == CNT_ZERO)
                begin
                    n.cnt  = st.data;                               // RQ7 RQ23
                    n.intr = 1'b1;
                end
                else
                    n.cnt = st.cnt - 16'h0001;                      // RQ7
            end
        end
        else if (st.en && is_capt)
        begin
            cap = start                                             // RQ12
                | (edge_ok && st.mode.start_trigger_select == STS_EDGE);
            if (cap)
            begin
                // Capture, clear and interrupt share one clock
                n.data          = st.cnt;                           // RQ11 RQ15
                n.cnt           = CNT_ZERO;
                n.overflow_flag = st.wrapped                        // RQ13 RQ14
                                | (tick && st.cnt == CNT_FULL);
                n.wrapped       = 1'b0;
                n.intr          = 1'b1;
            end
            else if (tick)
            begin
                n.cnt = st.cnt + 16'h0001;                          // RQ10 RQ25
                if (st.cnt == CNT_FULL)
                    n.wrapped = 1'b1;                               // RQ25
            end
        end
        // Stop wins over a start in the same cycle
        if (stop)
            n.en = 1'b0;                                            // RQ9
        if (n.intr && toe)
            n.tout = ~st.tout;                                      // RQ21
        if (clr)
            n = '0;                                                 // RQ2
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= n;
    end

endmodule : tecap_channel
`default_nettype wire

//--- tecap_pkg.sv
// Constants, register map and state types of the timer event count and capture unit
// How it works
// RQ1 - Software enables unit clock, then programs prescaler
// RQ2 - Unit disable resets everything, ignores register writes
// RQ3 - Input noise filter bypassed by select bit 0
// RQ4 - Software sets mode, reload, output enable first
// RQ5 - Start trigger sets enable status, self-clears
// RQ6 - Event start loads counter, waits for edge
// RQ7 - Each edge decrements; at zero reload and interrupt
// RQ8 - Software only rewrites data while counting
// RQ9 - Stop trigger clears enable, freezes counter
// RQ10 - Capture mode counts up from zero
// RQ11 - Edge captures, clears counter, interrupts, one clock
// RQ12 - Start trigger while running captures by software
// RQ13 - Capture updates overflow flag from wrap history
// RQ14 - Multiple wraps still just set overflow
// RQ15 - Interval equals period times full count
// RQ16 - Input sampled on selected operation clock
// RQ17 - Software selects edge start trigger code 001
// RQ18 - Switch bit routes serial receive to channel 7
// RQ19 - Channel 3 selects any of four clocks
// RQ20 - Only channels 3, 5, 6, 7 implemented
// RQ21 - Output enable 0 keeps timer output unchanged
// RQ22 - Software keeps master output mode, level zero
// RQ23 - Interrupt after reload value plus one edges
// RQ24 - Rewritten reload applies only at next reload
// RQ25 - Sixteen bit counter, upward wrap counts overflow
package tecap_pkg;

    // ********************************************************************
    // Sizes and channel numbering
    // ********************************************************************
    localparam int NUM_CH   = 4;
    localparam int CNT_W    = 16;
    localparam int PS_W     = 4;
    localparam int NUM_CK   = 4;
    localparam int SWITCHED_CH = 3;          // Index of channel 7
    localparam int CH3_IDX     = 0;          // Index of channel 3
    localparam int ISC_BIT     = 1;

    // ********************************************************************
    // Register map (byte addresses)
    // ********************************************************************
    localparam logic [11:0] ADDR_PER   = 12'h000; // peripheral_enable_reg
    localparam logic [11:0] ADDR_PS    = 12'h004; // prescaler_select_reg
    localparam logic [11:0] ADDR_NF    = 12'h008; // input_filter_enable_reg
    localparam logic [11:0] ADDR_ISC   = 12'h00c; // input switch control
    localparam logic [11:0] ADDR_START = 12'h010; // start trigger bits
    localparam logic [11:0] ADDR_STOP  = 12'h014; // stop trigger bits
    localparam logic [11:0] ADDR_EN    = 12'h018; // enable status bits
    localparam logic [11:0] ADDR_TOE   = 12'h01c; // output enable bits
    localparam logic [11:0] ADDR_TO    = 12'h020; // timer output values
    localparam logic [5:0]  CH_BLOCK   = 6'h01;   // Channel blocks at 0x40 + 0x10*idx
    localparam logic [1:0]  CH_MODE    = 2'h0;
    localparam logic [1:0]  CH_DATA    = 2'h1;
    localparam logic [1:0]  CH_CNT     = 2'h2;
    localparam logic [1:0]  CH_STAT    = 2'h3;

    // ********************************************************************
    // Mode register field codes and reset values
    // ********************************************************************
    localparam logic [2:0] OPM_EVENT   = 3'h3;
    localparam logic [2:0] OPM_CAPTURE = 3'h2;
    localparam logic [2:0] STS_EDGE    = 3'h1;
    localparam logic [1:0] CIS_FALL    = 2'h0;
    localparam logic [1:0] CIS_RISE    = 2'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
    localparam logic [15:0] DIV_ONE    = 16'h0001;

    typedef struct packed {
        logic [1:0] operation_clock_select;
        logic [2:0] rsv_a;
        logic [2:0] start_trigger_select;
        logic [1:0] edge_select;
        logic [1:0] rsv_b;
        logic [2:0] op_mode;
        logic       start_interrupt_select;
    } tecap_mode_s;

    // Per-channel state
    typedef struct packed {
        tecap_mode_s      mode;
        logic [CNT_W-1:0] data;
        logic [CNT_W-1:0] cnt;
        logic             overflow_flag;
        logic             wrapped;
        logic             en;
        logic [1:0]       samp;
        logic             filt;
        logic             intr;
        logic             tout;
    } tecap_ch_s;

    // Unit state
    typedef struct packed {
        logic              unit_clock_enable;
        logic [15:0]       ps;
        logic [NUM_CH-1:0] nf;
        logic              isc;
        logic [NUM_CH-1:0] toe;
        logic [15:0]       div;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } tecap_top_s;

endpackage : tecap_pkg

//--- tecap_pulse_source.sv
// Pulse source standing in for the external event lines
`timescale 1ns/1ps
`default_nettype none
module tecap_pulse_source
(
    input  wire logic       pclk,
    output logic      [3:0] timer_input_pin,
    output logic            serial_receive_pin
);
    // ********************************************************************
    // Lines idle low between pulses
    // ********************************************************************
    initial
    begin
        timer_input_pin    = 4'h0;
        serial_receive_pin = 1'b0;
    end

    // Index 4 picks the serial receive line
    task automatic set_line(input int sel, input logic lvl);
        begin
            if (sel == 4)
                serial_receive_pin <= lvl;
            else
                timer_input_pin[sel] <= lvl;
        end
    endtask : set_line

    // Six low cycles keep edges apart, even with the filter on
    task automatic burst(input int sel, input int n, input int w);
        begin
            repeat (n)
            begin
                @(posedge pclk);
                set_line(sel, 1'b1);
                repeat (w) @(posedge pclk);
                set_line(sel, 1'b0);
                repeat (6) @(posedge pclk);
            end
        end
    endtask : burst
endmodule : tecap_pulse_source
`default_nettype wire

//--- tecap_top.sv
// Timer event count and interval capture unit with APB register access
`timescale 1ns/1ps
`default_nettype none
module tecap_top
    import tecap_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_CH-1:0] timer_input_pin,
    input  wire logic              serial_receive_pin,
    output logic      [NUM_CH-1:0] channel_interrupt,
    output logic      [NUM_CH-1:0] timer_output_value
);

    tecap_top_s        s;
    tecap_top_s        next_s;
    tecap_ch_s         ch [NUM_CH];
    logic [NUM_CK-1:0] ck_tick;
    logic              wr;
    logic              setup;
    logic              ch_hit;
    logic [1:0]        ch_idx;
    logic [1:0]        ch_reg;
    logic [NUM_CH-1:0] start_v;
    logic [NUM_CH-1:0] stop_v;
    logic [NUM_CH-1:0] en_v;
    logic [NUM_CH-1:0] mode_wr;
    logic [NUM_CH-1:0] data_wr;
    logic              to_wr_any;
    logic [31:0]       rd;
    logic              rd_err;

    // ********************************************************************
    // APB decode
    // ********************************************************************
    // Write lands on the access edge, which always carries pready high
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite & s.pready;
    assign ch_hit = (paddr[11:6] == CH_BLOCK);
    assign ch_idx = paddr[5:4];
    assign ch_reg = paddr[3:2];

    // Trigger and write strobes; dropped while the unit is disabled
    always_comb
    begin
        start_v   = '0;
        stop_v    = '0;
        mode_wr   = '0;
        data_wr   = '0;
        to_wr_any = 1'b0;
        if (wr && s.unit_clock_enable)                              // RQ2
        begin
            if (paddr == ADDR_START)
                start_v = pwdata[NUM_CH-1:0];                       // RQ5
            if (paddr == ADDR_STOP)
                stop_v = pwdata[NUM_CH-1:0];                        // RQ9
            if (paddr == ADDR_TO)
                to_wr_any = 1'b1;
            if (ch_hit && ch_reg == CH_MODE)
                mode_wr[ch_idx] = 1'b1;
            if (ch_hit && ch_reg == CH_DATA)
                data_wr[ch_idx] = 1'b1;
        end
    end

    // ********************************************************************
    // Prescaled clock enables
    // ********************************************************************
    // Each clock is a one-cycle pulse every 2^setting cycles of pclk
    generate
        for (genvar k = 0; k < NUM_CK; k++)
        begin : g_ck
            logic [PS_W-1:0] sel;
            logic [15:0]     mask;
            assign sel        = s.ps[k*PS_W +: PS_W];
            assign mask       = (DIV_ONE << sel) - DIV_ONE;
            assign ck_tick[k] = s.unit_clock_enable && ((s.div & mask) == mask);
        end
    endgenerate

    // ********************************************************************
    // Channels 3, 5, 6 and 7
    // ********************************************************************
    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_ch                                                // RQ20
            logic [1:0] cks;
            logic [1:0] ck_idx;
            logic       pin_sel;
            assign cks = ch[c].mode.operation_clock_select;
            // Only channel 3 may reach the two extra clocks
            assign ck_idx  = (c == CH3_IDX) ? {cks[0], cks[1]}      // RQ19
                                            : {1'b0, cks[1]};
            assign pin_sel = (c == SWITCHED_CH && s.isc)            // RQ18
                           ? serial_receive_pin : timer_input_pin[c];
            assign en_v[c]  = ch[c].en;
            assign channel_interrupt[c]  = ch[c].intr;
            assign timer_output_value[c] = ch[c].tout;

            tecap_channel u_ch (
                .pclk    (pclk),
                .presetn (presetn),
                .clr     (~s.unit_clock_enable),
                .tick    (ck_tick[ck_idx]),
                .filt_en (s.nf[c]),
                .pin     (pin_sel),
                .start   (start_v[c]),
                .stop    (stop_v[c]),
                .toe     (s.toe[c]),
                .mode_wr (mode_wr[c]),
                .data_wr (data_wr[c]),
                .to_wr   (to_wr_any),
                .wdata   (to_wr_any ? {15'h0000, pwdata[c]} : pwdata[15:0]),
                .st      (ch[c])
            );
        end
    endgenerate

    // ********************************************************************
    // Read mux
    // ********************************************************************
    // Reads from a disabled unit see reset values since all state is cleared
    always_comb
    begin
        rd     = 32'h0000_0000;
        rd_err = 1'b0;
        if (ch_hit)
        begin
            unique case (ch_reg)
                CH_MODE: rd[15:0] = ch[ch_idx].mode;
                CH_DATA: rd[15:0] = ch[ch_idx].data;
                CH_CNT:  rd[15:0] = ch[ch_idx].cnt;
                CH_STAT: rd[0]    = ch[ch_idx].overflow_flag;
            endcase
        end
        else
        begin
            unique case (paddr)
                ADDR_PER:   rd[0]          = s.unit_clock_enable;
                ADDR_PS:    rd[15:0]       = s.ps;
                ADDR_NF:    rd[NUM_CH-1:0] = s.nf;
                ADDR_ISC:   rd[ISC_BIT]    = s.isc;
                ADDR_START: rd             = 32'h0000_0000;
                ADDR_STOP:  rd             = 32'h0000_0000;
                ADDR_EN:    rd[NUM_CH-1:0] = en_v;
                ADDR_TOE:   rd[NUM_CH-1:0] = s.toe;
                ADDR_TO:    rd[NUM_CH-1:0] = timer_output_value;
                default:    rd_err         = 1'b1;
            endcase
        end
    end

    // ********************************************************************
    // Unit state
    // ********************************************************************
    always_comb
    begin
        next_s         = s;
        next_s.div     = s.div + 16'h0001;
        // Answer in the first access cycle, from flops loaded at setup
        next_s.pready  = setup;
        next_s.pslverr = setup & rd_err;
        if (setup)
            next_s.prdata = rd;
        if (wr && paddr == ADDR_PER)
            next_s.unit_clock_enable = pwdata[0];                   // RQ1
        if (wr && s.unit_clock_enable)                              // RQ2
        begin
            unique case (paddr)
                ADDR_PS:  next_s.ps  = pwdata[15:0];
                ADDR_NF:  next_s.nf  = pwdata[NUM_CH-1:0];
                ADDR_ISC: next_s.isc = pwdata[ISC_BIT];
                ADDR_TOE: next_s.toe = pwdata[NUM_CH-1:0];
                default:  next_s.isc = s.isc;
            endcase
        end
        // A disabled unit holds every setting and divider at reset value
        if (!s.unit_clock_enable)                                   // RQ2
        begin
            next_s.ps  = '0;
            next_s.nf  = '0;
            next_s.isc = 1'b0;
            next_s.toe = '0;
            next_s.div = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;

endmodule : tecap_top
`default_nettype wire
